// >>> core/sar_frame_pkg.sv
/*
 * Shared constants and carrier types for the serial frame control of an
 * eight-channel 12-bit successive-approximation converter.
 * Assumes a single system clock; serial pins are asynchronous to it.
 */
package sar_frame_pkg;

    // ------------------------------------------------------------
    // Conversion format
    // ------------------------------------------------------------
    localparam int CODE_BITS    = 12;
    localparam int CODE_STEPS   = 4096;
    localparam int NUM_CHANNELS = 8;
    localparam int CHAN_BITS    = 3;

    // ------------------------------------------------------------
    // Serial clock counts per conversion
    // ------------------------------------------------------------
    localparam int CONV_CLKS  = 16;
    localparam int TRACK_CLKS = 3;
    localparam int HOLD_CLKS  = 13;
    localparam int LEAD_ZEROS = 4;
    localparam int CNT_BITS   = 5;

    // ------------------------------------------------------------
    // Command word layout
    // ------------------------------------------------------------
    localparam int CMD_BITS = 8;
    localparam int CHAN_MSB = 5;
    localparam int CHAN_LSB = 3;

    // ------------------------------------------------------------
    // Reset values and buffering
    // ------------------------------------------------------------
    localparam logic [CHAN_BITS-1:0] RESET_CHANNEL = 3'h0;
    localparam logic [CMD_BITS-1:0]  RESET_CMD     = 8'h00;
    localparam int                   FIFO_DEPTH    = 32;

    // ------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------
    typedef struct packed {
        logic cs_n;
        logic sclk;
        logic din;
    } pins_t;

    typedef struct packed {
        logic                 start;
        logic [CHAN_BITS-1:0] channel;
    } conv_req_t;

    typedef struct packed {
        logic track;
        logic hold;
        logic powered;
    } mode_t;

endpackage

// >>> core/sar_result_fifo.sv
/*
 * Result FIFO: flip-flop storage, valid and ready on both sides.
 * Assumes DEPTH is a power of two and one clock for both sides.
 */
`timescale 1ns/10ps
module sar_result_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input  wire logic             sys_clk,
    input  wire logic             nrst,
    // Fill side
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    // Drain side
    output logic [WIDTH-1:0]      out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem_r   [DEPTH];
    logic [WIDTH-1:0] mem_nxt [DEPTH];
    logic [AW-1:0]    wr_ptr_r;
    logic [AW-1:0]    wr_ptr_nxt;
    logic [AW-1:0]    rd_ptr_r;
    logic [AW-1:0]    rd_ptr_nxt;
    logic [CW-1:0]    count_r;
    logic [CW-1:0]    count_nxt;
    logic             rdy_r;
    logic             rdy_nxt;
    logic             valid_r;
    logic             valid_nxt;
    logic             push;
    logic             pop;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        push       = in_valid & rdy_r;
        pop        = out_ready & valid_r;
        mem_nxt    = mem_r;
        wr_ptr_nxt = wr_ptr_r;
        rd_ptr_nxt = rd_ptr_r;
        if (push)
        begin
            mem_nxt[wr_ptr_r] = in_data;
            wr_ptr_nxt        = AW'(wr_ptr_r + 1'b1);
        end
        if (pop)
        begin
            rd_ptr_nxt = AW'(rd_ptr_r + 1'b1);
        end
        count_nxt = CW'(count_r + CW'(push) - CW'(pop));
        rdy_nxt   = (count_nxt != CW'(DEPTH));
        valid_nxt = (count_nxt != '0);
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
            rdy_r    <= 1'b0;
            valid_r  <= 1'b0;
        end
        else
        begin
            wr_ptr_r <= wr_ptr_nxt;
            rd_ptr_r <= rd_ptr_nxt;
            count_r  <= count_nxt;
            rdy_r    <= rdy_nxt;
            valid_r  <= valid_nxt;
        end
        mem_r <= mem_nxt;
    end

    assign in_ready  = rdy_r;
    assign out_valid = valid_r;
    assign out_data  = mem_r[rd_ptr_r];

endmodule

// >>> core/sar_frame_ctrl.sv
/*
 * Serial frame control of an eight-channel 12-bit SAR converter.
 * Samples chip select, serial clock and command input on sys_clk,
 * sequences track and hold, picks the channel, shifts results out.
 * Assumes the serial clock is much slower than sys_clk (8x or more)
 * and a front end that pushes one code per conversion request.
 */
// Summary of operation
// - Results are unsigned straight binary 12-bit codes, step is supply over 4096.
// - A frame starts when chip select falls and ends when it rises.
// - Serial output enabled only while chip select is low.
// - Serial clock ignored while chip select is high.
// - First 3 serial clock cycles of a conversion are track mode.
// - Next 13 cycles are hold mode, converting and shifting out.
// - Falling edges 1-4 send zeros, 5-16 send the code MSB first.
// - Track re-entered after every 16th rising edge, hold at edge N*16+4.
// - Chip select falling with clock high: next clock fall is edge 1.
// - Chip select falling with clock low counts as falling edge 1.
// - Chip select and clock falling together also start track mode.
// - Command word sampled MSB first on the first 8 rising edges.
// - Channel from one command applies to the next conversion.
// - First conversion after reset uses RESET_CHANNEL, channel 0.
// - Command bits 5 to 3 carry the channel code, others ignored.
// - Channel code n selects analog input n.
// - Powered while chip select low, down between edge 16 and next edge 1.
`timescale 1ns/10ps
module sar_frame_ctrl
    import sar_frame_pkg::*;
#(
    parameter int FIFO_WORDS = FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic                    sys_clk,
    input  wire logic                    nrst,
    // Serial pins
    input  wire logic                    cs_n,
    input  wire logic                    sclk,
    input  wire logic                    din,
    output logic                         dout,
    output logic                         dout_oe,
    // Result stream from the converter core
    input  wire logic [CODE_BITS-1:0]    res_data,
    input  wire logic                    res_valid,
    output logic                         res_ready,
    // Converter core control
    output conv_req_t                    conv_req,
    output mode_t                        mode,
    output logic [NUM_CHANNELS-1:0]      mux_sel,
    // Status pulses
    output logic                         frame_err,
    output logic                         underrun
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    pins_t                   pins_in;
    pins_t                   sync1_r;
    pins_t                   sync2_r;
    pins_t                   prev_r;
    logic                    cs_fall;
    logic                    cs_rise;
    logic                    sclk_fall;
    logic                    sclk_rise;
    logic                    fall_ev;
    logic                    rise_ev;
    logic [CNT_BITS-1:0]     fall_cnt_r;
    logic [CNT_BITS-1:0]     fall_cnt_nxt;
    logic [CNT_BITS-1:0]     rise_cnt_r;
    logic [CNT_BITS-1:0]     rise_cnt_nxt;
    logic [CMD_BITS-1:0]     cmd_r;
    logic [CMD_BITS-1:0]     cmd_nxt;
    logic [CMD_BITS-1:0]     cmd_shift;
    logic [CHAN_BITS-1:0]    next_chan_r;
    logic [CHAN_BITS-1:0]    next_chan_nxt;
    logic [CHAN_BITS-1:0]    cur_chan_r;
    logic [CHAN_BITS-1:0]    cur_chan_nxt;
    logic [CODE_BITS-1:0]    shift_r;
    logic [CODE_BITS-1:0]    shift_nxt;
    logic [CODE_BITS-1:0]    code;
    logic                    dout_r;
    logic                    dout_nxt;
    logic                    oe_r;
    logic                    oe_nxt;
    conv_req_t               req_r;
    conv_req_t               req_nxt;
    mode_t                   mode_r;
    mode_t                   mode_nxt;
    logic [NUM_CHANNELS-1:0] sel_r;
    logic [NUM_CHANNELS-1:0] sel_nxt;
    logic                    ferr_r;
    logic                    ferr_nxt;
    logic                    under_r;
    logic                    under_nxt;
    logic                    pop;
    logic [CODE_BITS-1:0]    fifo_data;
    logic                    fifo_valid;
    typedef enum logic [2:0]
    {
        IDLE       = 3'b000,
        ARMED      = 3'b001,
        TRACK      = 3'b010,
        HOLD       = 3'b011,
        POWER_DOWN = 3'b100
    } phase_t;
    phase_t                  phase;

    // ------------------------------------------------------------
    // Pin synchronisers and edge detection
    // ------------------------------------------------------------
    assign pins_in = '{cs_n: cs_n, sclk: sclk, din: din};

    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            sync1_r <= '{cs_n: 1'b1, sclk: 1'b0, din: 1'b0};
            sync2_r <= '{cs_n: 1'b1, sclk: 1'b0, din: 1'b0};
            prev_r  <= '{cs_n: 1'b1, sclk: 1'b0, din: 1'b0};
        end
        else
        begin
            sync1_r <= pins_in;
            sync2_r <= sync1_r;
            prev_r  <= sync2_r;
        end
    end

    always_comb
    begin
        cs_fall   = prev_r.cs_n & ~sync2_r.cs_n;
        cs_rise   = ~prev_r.cs_n & sync2_r.cs_n;
        sclk_fall = prev_r.sclk & ~sync2_r.sclk;
        sclk_rise = ~prev_r.sclk & sync2_r.sclk;
        // Chip select low gates the clock; a chip select fall with the
        // clock low, alone or together with a clock fall, is edge 1
        fall_ev   = ~sync2_r.cs_n & ~sync2_r.sclk & (cs_fall | sclk_fall);
        rise_ev   = ~sync2_r.cs_n & sclk_rise & (fall_cnt_r != '0);
    end

    // ------------------------------------------------------------
    // Result buffer
    // ------------------------------------------------------------
    sar_result_fifo #(
        .WIDTH (CODE_BITS),
        .DEPTH (FIFO_WORDS)
    ) u_fifo (
        .sys_clk   (sys_clk),
        .nrst      (nrst),
        .in_data   (res_data),
        .in_valid  (res_valid),
        .in_ready  (res_ready),
        .out_data  (fifo_data),
        .out_valid (fifo_valid),
        .out_ready (pop)
    );

    // ------------------------------------------------------------
    // Channel decode
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < NUM_CHANNELS; gi++)
        begin : g_sel
            assign sel_nxt[gi] = (cur_chan_nxt == CHAN_BITS'(gi));
        end
    endgenerate

    // ------------------------------------------------------------
    // Frame sequencer next state
    // ------------------------------------------------------------
    always_comb
    begin
        fall_cnt_nxt  = fall_cnt_r;
        rise_cnt_nxt  = rise_cnt_r;
        cmd_nxt       = cmd_r;
        next_chan_nxt = next_chan_r;
        cur_chan_nxt  = cur_chan_r;
        shift_nxt     = shift_r;
        dout_nxt      = dout_r;
        req_nxt       = '{start: 1'b0, channel: req_r.channel};
        ferr_nxt      = 1'b0;
        under_nxt     = 1'b0;
        pop           = 1'b0;
        code          = '0;
        cmd_shift     = {cmd_r[CMD_BITS-2:0], sync2_r.din};
        oe_nxt        = ~sync2_r.cs_n;

        if (cs_rise)
        begin
            // Frame end aborts any conversion in progress
            fall_cnt_nxt = '0;
            rise_cnt_nxt = '0;
            dout_nxt     = 1'b0;
            ferr_nxt     = (rise_cnt_r != '0) &&
                           (rise_cnt_r != CNT_BITS'(CONV_CLKS));
        end
        else if (cs_fall && sync2_r.sclk)
        begin
            fall_cnt_nxt = '0;
            rise_cnt_nxt = '0;
            dout_nxt     = 1'b0;
        end
        else if (fall_ev)
        begin
            if ((fall_cnt_r == '0) || (fall_cnt_r == CNT_BITS'(CONV_CLKS)))
            begin
                // New conversion: track again, adopt the queued channel
                fall_cnt_nxt = CNT_BITS'(1);
                rise_cnt_nxt = '0;
                cur_chan_nxt = next_chan_r;
                dout_nxt     = 1'b0;
            end
            else
            begin
                fall_cnt_nxt = CNT_BITS'(fall_cnt_r + 1'b1);
                if (fall_cnt_nxt <= CNT_BITS'(LEAD_ZEROS))
                begin
                    dout_nxt = 1'b0;
                end
                if (fall_cnt_nxt == CNT_BITS'(LEAD_ZEROS))
                begin
                    // Hold entry starts the conversion in the core
                    req_nxt = '{start: 1'b1, channel: cur_chan_r};
                end
                else if (fall_cnt_nxt == CNT_BITS'(LEAD_ZEROS + 1))
                begin
                    // First result bit: take the code from the buffer
                    if (fifo_valid)
                    begin
                        code = fifo_data;
                        pop  = 1'b1;
                    end
                    else
                    begin
                        under_nxt = 1'b1;
                    end
                    dout_nxt  = code[CODE_BITS-1];
                    shift_nxt = {code[CODE_BITS-2:0], 1'b0};
                end
                else if (fall_cnt_nxt > CNT_BITS'(LEAD_ZEROS + 1))
                begin
                    dout_nxt  = shift_r[CODE_BITS-1];
                    shift_nxt = {shift_r[CODE_BITS-2:0], 1'b0};
                end
            end
        end
        else if (rise_ev)
        begin
            if (rise_cnt_r < CNT_BITS'(CONV_CLKS))
            begin
                rise_cnt_nxt = CNT_BITS'(rise_cnt_r + 1'b1);
            end
            if (rise_cnt_r < CNT_BITS'(CMD_BITS))
            begin
                cmd_nxt = cmd_shift;
            end
            if (rise_cnt_r == CNT_BITS'(CMD_BITS - 1))
            begin
                next_chan_nxt = cmd_shift[CHAN_MSB:CHAN_LSB];
            end
        end

        // Phase follows the falling edge count of the conversion
        if (sync2_r.cs_n)
        begin
            phase = IDLE;
        end
        else if (fall_cnt_nxt == '0)
        begin
            phase = ARMED;
        end
        else if (fall_cnt_nxt <= CNT_BITS'(TRACK_CLKS))
        begin
            phase = TRACK;
        end
        else if (fall_cnt_nxt != CNT_BITS'(CONV_CLKS))
        begin
            phase = HOLD;
        end
        else
        begin
            phase = POWER_DOWN;
        end

        // Mode outputs of each phase
        case (phase)
            ARMED:      mode_nxt = '{track: 1'b0, hold: 1'b0, powered: 1'b1};
            TRACK:      mode_nxt = '{track: 1'b1, hold: 1'b0, powered: 1'b1};
            HOLD:       mode_nxt = '{track: 1'b0, hold: 1'b1, powered: 1'b1};
            POWER_DOWN: mode_nxt = '{track: 1'b0, hold: 1'b1, powered: 1'b0};
            default:    mode_nxt = '{track: 1'b0, hold: 1'b0, powered: 1'b0};
        endcase
    end

    // ------------------------------------------------------------
    // Frame sequencer registers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            fall_cnt_r  <= '0;
            rise_cnt_r  <= '0;
            cmd_r       <= RESET_CMD;
            next_chan_r <= RESET_CHANNEL;
            cur_chan_r  <= RESET_CHANNEL;
            shift_r     <= '0;
            dout_r      <= 1'b0;
            oe_r        <= 1'b0;
            req_r       <= '{start: 1'b0, channel: RESET_CHANNEL};
            mode_r      <= '{track: 1'b0, hold: 1'b0, powered: 1'b0};
            sel_r       <= '0;
            ferr_r      <= 1'b0;
            under_r     <= 1'b0;
        end
        else
        begin
            fall_cnt_r  <= fall_cnt_nxt;
            rise_cnt_r  <= rise_cnt_nxt;
            cmd_r       <= cmd_nxt;
            next_chan_r <= next_chan_nxt;
            cur_chan_r  <= cur_chan_nxt;
            shift_r     <= shift_nxt;
            dout_r      <= dout_nxt;
            oe_r        <= oe_nxt;
            req_r       <= req_nxt;
            mode_r      <= mode_nxt;
            sel_r       <= sel_nxt;
            ferr_r      <= ferr_nxt;
            under_r     <= under_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign dout      = dout_r;
    assign dout_oe   = oe_r;
    assign conv_req  = req_r;
    assign mode      = mode_r;
    assign mux_sel   = sel_r;
    assign frame_err = ferr_r;
    assign underrun  = under_r;

endmodule

// >>> verification/sar_frame_ctrl_properties.sv
/*
 * Port checker for sar_frame_ctrl, bound to every instance.
 * Assumes a serial clock period of at least 8 sys_clk.
 */
`timescale 1ns/10ps
module sar_frame_ctrl_properties
    import sar_frame_pkg::*;
#(
    parameter int FIFO_WORDS = FIFO_DEPTH
) (
    // Clock and reset
    input wire logic                    sys_clk,
    input wire logic                    nrst,
    // Serial pins
    input wire logic                    cs_n,
    input wire logic                    dout,
    input wire logic                    dout_oe,
    // Core side
    input wire logic                    res_ready,
    input wire conv_req_t               conv_req,
    input wire mode_t                   mode,
    input wire logic [NUM_CHANNELS-1:0] mux_sel,
    // Status
    input wire logic                    frame_err,
    input wire logic                    underrun
);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    property p_oe_off; cs_n [*5] |-> !dout_oe; endproperty
    property p_oe_on; !cs_n [*5] |-> dout_oe; endproperty
    property p_dout_idle; !dout_oe |-> !dout; endproperty
    property p_gated; cs_n [*6] |-> !conv_req.start && $stable(mux_sel); endproperty
    property p_excl; !(mode.track && mode.hold); endproperty
    property p_track_len; $rose(mode.hold) |-> $past(mode.track, 20); endproperty
    property p_hold_len; $rose(mode.hold) |=> (mode.hold || cs_n) [*8]; endproperty
    property p_lead_zero; $rose(mode.hold) |-> !dout && !$past(dout, 8); endproperty
    property p_hold_start; $rose(mode.hold) |-> conv_req.start; endproperty
    property p_mux; conv_req.start |-> mux_sel == (8'h01 << conv_req.channel); endproperty
    property p_power_off; cs_n [*6] |-> !mode.powered; endproperty
    property p_power_on; $rose(mode.track) |-> mode.powered; endproperty

    a_oe_off: assert property (p_oe_off) else $error("output on while deselected");
    a_oe_on: assert property (p_oe_on) else $error("output off while selected");
    a_dout_idle: assert property (p_dout_idle) else $error("idle output not low");
    a_gated: assert property (p_gated) else $error("clock acted while deselected");
    a_excl: assert property (p_excl) else $error("track and hold together");
    a_track_len: assert property (p_track_len) else $error("track phase too short");
    a_hold_len: assert property (p_hold_len) else $error("hold phase too short");
    a_lead_zero: assert property (p_lead_zero) else $error("leading bit not zero");
    a_hold_start: assert property (p_hold_start) else $error("hold without start");
    a_mux: assert property (p_mux) else $error("input select wrong");
    a_power_off: assert property (p_power_off) else $error("powered while deselected");
    a_power_on: assert property (p_power_on) else $error("tracking while powered down");

    c_start: cover property (conv_req.start);
    c_frame_err: cover property (frame_err);
    c_underrun: cover property (underrun);
    c_full: cover property ($fell(res_ready));
endmodule

bind sar_frame_ctrl sar_frame_ctrl_properties #(.FIFO_WORDS(FIFO_WORDS)) chk_u (
    .sys_clk(sys_clk), .nrst(nrst), .cs_n(cs_n), .dout(dout), .dout_oe(dout_oe),
    .res_ready(res_ready), .conv_req(conv_req), .mode(mode), .mux_sel(mux_sel),
    .frame_err(frame_err), .underrun(underrun)
);

// >>> verification/sar_host_model.sv
/*
 * Host side model: frames, serial clock of 200 ns, command words, result capture.
 * Assumes dout_pin already resolves the released line.
 */
`timescale 1ns/10ps
module sar_host_model
    import sar_frame_pkg::*;
(
    // Clock and return line
    input  wire logic sys_clk,
    input  wire logic dout_pin,
    // Serial outputs
    output logic      cs_n,
    output logic      sclk,
    output logic      din
);
    logic [15:0] rx_q[$];

    initial
    begin
        cs_n = 1'b1;
        sclk = 1'b1;
        din = 1'b0;
    end

    // ------------------------------------------------------------
    // Frame: start 0 clock high, 1 clock low, 2 both fall together
    // ------------------------------------------------------------
    task automatic frame(input int start, input int nbits, input logic [63:0] cmds);
        logic [15:0] w;
        w = 16'h0000;
        @(posedge sys_clk);
        #1;
        sclk = (start != 1);
        #100;
        cs_n = 1'b0;
        if (start == 2)
            sclk = 1'b0;
        if (start == 0)
        begin
            #100;
            sclk = 1'b0;
        end
        for (int b = 0; b < nbits; b++)
        begin
            din = (b % 16 < 8) ? cmds[8 * (b / 16) + 7 - b % 16] : 1'b0;
            #100;
            sclk = 1'b1;
            #90;
            w = {w[14:0], dout_pin};
            if (b % 16 == 15)
                rx_q.push_back(w);
            #10;
            if (b != nbits - 1)
                sclk = 1'b0;
        end
        cs_n = 1'b1;
        repeat (4)
        begin
            #100;
            sclk = ~sclk;
        end
    endtask
endmodule

// >>> verification/tb.sv
/*
 * Self-checking bench for sar_frame_ctrl.
 * Assumes the host model drives the pins and the bench feeds codes.
 */
`timescale 1ns/10ps
module tb;
    import sar_frame_pkg::*;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic                    sys_clk;
    logic                    nrst;
    logic                    cs_n;
    logic                    sclk;
    logic                    din;
    logic                    dout;
    logic                    dout_oe;
    logic                    dout_pin;
    logic                    last_d = 1'b0;
    logic [CODE_BITS-1:0]    res_data;
    logic                    res_valid;
    logic                    res_ready;
    conv_req_t               conv_req;
    mode_t                   mode;
    logic [NUM_CHANNELS-1:0] mux_sel;
    logic                    frame_err;
    logic                    underrun;
    logic [CHAN_BITS-1:0]    exp_ch;
    logic [CHAN_BITS-1:0]    ch_q[$];
    logic [CODE_BITS-1:0]    code_q[$];
    logic [CODE_BITS-1:0]    codes[5] = '{12'hFFF, 12'h801, 12'h7FE, 12'h001, 12'h5A5};
    int                      n_mismatch = 0;
    int                      n_tests = 0;
    int                      n_err = 0;
    int                      n_under = 0;
    int                      n_acc;

    sar_frame_ctrl #(.FIFO_WORDS(4)) dut_u (
        .sys_clk(sys_clk), .nrst(nrst), .cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout),
        .dout_oe(dout_oe), .res_data(res_data), .res_valid(res_valid), .res_ready(res_ready),
        .conv_req(conv_req), .mode(mode), .mux_sel(mux_sel), .frame_err(frame_err),
        .underrun(underrun)
    );
    sar_host_model host_u (
        .sys_clk(sys_clk), .dout_pin(dout_pin), .cs_n(cs_n), .sclk(sclk), .din(din)
    );

    initial
    begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    // ------------------------------------------------------------
    // Line resolution and monitors
    // ------------------------------------------------------------
    assign dout_pin = dout_oe ? dout : ~last_d;
    always @(negedge sys_clk)
    begin
        if (dout_oe === 1'b1)
            last_d <= dout;
        if (conv_req.start === 1'b1)
            ch_q.push_back(conv_req.channel);
        if (frame_err === 1'b1)
            n_err++;
        if (underrun === 1'b1)
            n_under++;
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic do_frame(input string name, input int start, input int nbits,
                            input logic [63:0] cmds);
        logic [15:0] exp_w;
        host_u.frame(start, nbits, cmds);
        repeat (8) @(posedge sys_clk);
        #1;
        for (int c = 0; c < (nbits + 15) / 16; c++)
        begin
            exp_w = (code_q.size() > 0) ? {4'h0, code_q.pop_front()} : 16'h0000;
            check("channel", ch_q.pop_front(), exp_ch);
            if (nbits >= 16 * c + 16)
                check("result", host_u.rx_q.pop_front(), exp_w);
            if (nbits >= 16 * c + 8)
                exp_ch = cmds[8 * c + 3 +: 3];
        end
        check("enable", dout_oe, 1'b0);
        $display("test %s done", name);
    endtask

    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial
    begin
        nrst = 1'b0;
        res_valid = 1'b0;
        res_data = 12'h000;
        exp_ch = RESET_CHANNEL;
        repeat (2) @(posedge sys_clk);
        #1;
        check("reset enable", dout_oe, 1'b0);
        check("reset mode", mode, 3'h0);
        nrst = 1'b1;
        repeat (2) @(posedge sys_clk);
        #1;
        check("ready", res_ready, 1'b1);
        $display("test reset done");
        n_acc = 0;
        res_valid = 1'b1;
        for (int i = 0; i < 12; i++)
        begin
            res_data = codes[n_acc];
            if (res_ready === 1'b1)
            begin
                code_q.push_back(codes[n_acc]);
                n_acc++;
            end
            @(posedge sys_clk);
            #1;
        end
        res_valid = 1'b0;
        check("accepted", n_acc, 4);
        check("full", res_ready, 1'b0);
        $display("test fill done");
        do_frame("dummy", 0, 16, 64'hEF);
        do_frame("clock low", 1, 32, 64'h3810);
        do_frame("together", 2, 16, 64'hC0);
        check("drained", res_ready, 1'b1);
        do_frame("abort", 0, 6, 64'h08);
        do_frame("continuous", 1, 128, 64'h0038302820181008);
        check("frame errors", n_err, 1);
        check("underruns", n_under, 9);
        give_verdict();
    end

    initial
    begin
        #200000;
        n_mismatch++;
        $display("mismatch watchdog expected finish seen hang");
        give_verdict();
    end
endmodule
